// file: riv_defs.svh
`ifndef RIV_DEFS_SVH
`define RIV_DEFS_SVH

// Data path widths
`define RIV_SEG_W          5
`define RIV_GPR_W          16
`define RIV_GPR_N          32
`define RIV_GPR_SEL_W      5
`define RIV_DADDR_W        21
`define RIV_INSTR_W        22
`define RIV_STATUS_W       16
`define RIV_PC_W           16
`define RIV_RADDR_W        9
`define RIV_VEC_N          32
`define RIV_VEC_W          5

// Core-only register space
`define RIV_ADDR_VEC_ACK   9'h007
`define RIV_ADDR_STAT_RET  9'h008
`define RIV_ADDR_PC_RET    9'h009
`define RIV_ADDR_INSTR_LO  9'h00A
`define RIV_ADDR_INSTR_HI  9'h00B
`define RIV_ADDR_SCR_HI    9'h00C
`define RIV_ADDR_SCR_LO    9'h00D

// Program and data map
`define RIV_VEC_START      16'h0000
`define RIV_DM_BASE        21'h0_0200
`define RIV_EXT_BASE       21'h0_0400

// Reset values
`define RIV_SEG_RST        5'h00
`define RIV_WORD_RST       16'h0000

`endif

// file: riv_pkg.sv
package riv_pkg;

    typedef enum logic [1:0] {
        RIV_ST_HALT = 2'b01,
        RIV_ST_RUN  = 2'b10
    } riv_state_t;

    typedef enum logic [2:0] {
        RIV_REG_SPACE = 3'b001,
        RIV_INT_DM    = 3'b010,
        RIV_EXT_MEM   = 3'b100
    } riv_region_t;

endpackage

// file: riv_gpr_file.sv
`timescale 1ns/1ps
`include "riv_defs.svh"

module riv_gpr_file (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [4:0]  rs_a_sel,
    input  wire logic [4:0]  rs_b_sel,
    output logic      [15:0] rs_a_data,
    output logic      [15:0] rs_b_data,
    input  wire logic        wb_en,
    input  wire logic [4:0]  wb_sel,
    input  wire logic [15:0] wb_data
);
    logic [15:0] gpr_reg [`RIV_GPR_N];

    // Register 0 never stores; writes to it vanish
    genvar gi;
    generate
        for (gi = 0; gi < `RIV_GPR_N; gi++) begin : g_gpr
            always_ff @(posedge clk) begin
                if (srst) begin
                    gpr_reg[gi] <= `RIV_WORD_RST;
                end else if (ce && wb_en && gi != 0 &&
                             wb_sel == `RIV_GPR_SEL_W'(gi)) begin
                    gpr_reg[gi] <= wb_data;
                end
            end
        end
    endgenerate

    // Zero source for register 0
    assign rs_a_data = (rs_a_sel == 5'h00) ? 16'h0000
                                           : gpr_reg[rs_a_sel];
    assign rs_b_data = (rs_b_sel == 5'h00) ? 16'h0000
                                           : gpr_reg[rs_b_sel];

    zero_src_a: assert property (@(posedge clk) disable iff (srst)
        (rs_a_sel == 5'h00) |-> (rs_a_data == 16'h0000))
        else $error("register 0 source not zero");

    zero_dest_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wb_en && wb_sel == 5'h00) |=> (gpr_reg[0] == 16'h0000))
        else $error("write to register 0 became visible");

    gpr_write_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wb_en && wb_sel != 5'h00) ##1
        (rs_a_sel == $past(wb_sel) && !(wb_en && ce))
        |-> (rs_a_data == $past(wb_data)))
        else $error("general register did not take write");
endmodule

// file: riv_exception_unit.sv
`timescale 1ns/1ps
`include "riv_defs.svh"

// Overview of operation
// - Data address is segment in bits 20..16, register in 15..0.
// - Segment extends data reach from 64K to 2M bytes.
// - Segment is write-only, loaded only by set-segment with imm5.
// - Thirty-two 16-bit general registers, numbered 0 to 31.
// - Register 0 always reads as zero when used as source.
// - Writes to register 0 are discarded, nothing changes.
// - Vectors 0-1Fh: start, 15 engine, 16 DMA count.
// - Vectors 1-7: motion, filter, inverse, forward, ext DMA, ext, varlen.
// - Vectors 8-Fh: timers, timer0, timer1, host, decoder, empty, full.
// - Vectors 10h-1Fh: frame DMA channels 0-15 terminal count.
// - After host enables the core, fetch starts at 0000h.
// - Taking an interrupt loads the PC with its vector address.
// - Taking an interrupt masks all other interrupts until re-enabled.
// - Take saves fetch address, decode instruction, execute status.
// - Reading vector register acknowledges the interrupting source.
// - Unmask instruction re-enables interrupt inputs.
// - Return restores saved state from shadows and resumes.
// - Call instruction performs the same shadow save.
// - Shadow registers reachable only by the core, never the host.
// - Shadow map 008h status to 00Dh scratch low, scratch read-only.
// - Data map: register file, internal RAM, external from 400h.
// - Three pipeline stages define what is captured on interrupt.
module riv_exception_unit (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic         core_enable,
    input  wire logic [14:0]  engine_irq,
    input  wire logic [15:0]  dma_tc_irq,
    output logic      [14:0]  engine_ack,
    output logic      [15:0]  dma_tc_ack,
    output logic              irq_masked,
    output logic              core_running,
    input  wire logic [15:0]  fetch_addr,
    input  wire logic [21:0]  decode_instr,
    input  wire logic [15:0]  exec_status,
    input  wire logic [31:0]  temp_result,
    input  wire logic         call_exec,
    input  wire logic         irq_unmask_instr,
    input  wire logic         return_instr,
    input  wire logic         set_segment_instr,
    input  wire logic [4:0]   seg_imm,
    output logic              pc_load,
    output logic      [15:0]  pc_load_addr,
    output logic              restore_valid,
    output logic      [15:0]  restore_pc,
    output logic      [21:0]  restore_instr,
    output logic      [15:0]  restore_status,
    input  wire logic         reg_rd_en,
    input  wire logic         reg_wr_en,
    input  wire logic [8:0]   reg_addr,
    input  wire logic [15:0]  reg_wr_data,
    output logic      [15:0]  reg_rd_data,
    output logic              reg_rd_valid,
    input  wire logic [4:0]   rs_a_sel,
    input  wire logic [4:0]   rs_b_sel,
    output logic      [15:0]  rs_a_data,
    output logic      [15:0]  rs_b_data,
    input  wire logic         wb_en,
    input  wire logic [4:0]   wb_sel,
    input  wire logic [15:0]  wb_data,
    input  wire logic         mem_req,
    output logic              mem_valid,
    output logic      [20:0]  mem_addr,
    output riv_pkg::riv_region_t mem_region
);
    import riv_pkg::*;

    riv_state_t  state_reg;
    logic        enable_prev_reg;
    logic [31:0] req_prev_reg;
    logic [31:0] pending_reg;
    logic        mask_reg;
    logic [4:0]  active_vec_reg;
    logic [4:0]  data_segment_reg;
    logic [15:0] status_return_reg;
    logic [15:0] pc_return_reg;
    logic [21:0] instr_return_reg;
    logic [31:0] scratch_result_reg;
    logic        pc_load_reg;
    logic [15:0] pc_load_addr_reg;
    logic        restore_valid_reg;
    logic [31:0] ack_reg;
    logic [15:0] rd_data_reg;
    logic        rd_valid_reg;
    logic        mem_valid_reg;
    logic [20:0] mem_addr_reg;
    riv_region_t mem_region_reg;

    logic [31:0] req_vec;
    logic [4:0]  lowest_vec;
    logic        any_pending;
    logic        take_irq;
    logic        start_core;
    logic        save_ctx;
    logic        ack_read;
    logic [20:0] daddr_next;

    // One-hot of a vector number, used to build the acknowledge pulse
    function automatic logic [31:0] vec_onehot(input logic [4:0] v);
        vec_onehot = 32'h0000_0001 << v;
    endfunction

    // Lowest set bit wins; bit 0 is the start entry and never requests
    function automatic logic [4:0] lowest_set(input logic [31:0] p);
        lowest_set = 5'h00;
        for (int i = `RIV_VEC_N - 1; i > 0; i--) begin
            if (p[i]) begin
                lowest_set = 5'(i);
            end
        end
    endfunction

    // Engine order 1..15, then frame DMA channels 0..15 at 10h..1Fh
    assign req_vec     = {dma_tc_irq, engine_irq, 1'b0};
    assign lowest_vec  = lowest_set(pending_reg);
    assign any_pending = |pending_reg;
    assign start_core  = core_enable && !enable_prev_reg &&
                         state_reg == RIV_ST_HALT;
    // Call and return own the shadows this cycle; a take waits one cycle
    assign take_irq    = state_reg == RIV_ST_RUN && !mask_reg &&
                         any_pending && !call_exec && !return_instr &&
                         !pc_load_reg;
    assign save_ctx    = take_irq || (state_reg == RIV_ST_RUN && call_exec);
    assign ack_read    = reg_rd_en && reg_addr == `RIV_ADDR_VEC_ACK;

    // Run state follows the host enable
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg       <= RIV_ST_HALT;
            enable_prev_reg <= 1'b0;
        end else if (ce) begin
            enable_prev_reg <= core_enable;
            case (state_reg)
                RIV_ST_HALT: begin
                    if (start_core) begin
                        state_reg <= RIV_ST_RUN;
                    end
                end
                RIV_ST_RUN: begin
                    if (!core_enable) begin
                        state_reg <= RIV_ST_HALT;
                    end
                end
                default: begin
                    state_reg <= RIV_ST_HALT;
                end
            endcase
        end
    end

    // Requests latch on their rising edge; a new edge beats the ack clear
    genvar gv;
    generate
        for (gv = 0; gv < `RIV_VEC_N; gv++) begin : g_pend
            always_ff @(posedge clk) begin
                if (srst) begin
                    req_prev_reg[gv] <= 1'b0;
                    pending_reg[gv]  <= 1'b0;
                end else if (ce) begin
                    req_prev_reg[gv] <= req_vec[gv];
                    if (req_vec[gv] && !req_prev_reg[gv]) begin
                        pending_reg[gv] <= 1'b1;
                    end else if (ack_read && active_vec_reg == 5'(gv)) begin
                        pending_reg[gv] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Mask and vector load
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg         <= 1'b1;
            active_vec_reg   <= 5'h00;
            pc_load_reg      <= 1'b0;
            pc_load_addr_reg <= `RIV_VEC_START;
        end else if (ce) begin
            pc_load_reg <= 1'b0;
            if (start_core) begin
                mask_reg         <= 1'b0;
                pc_load_reg      <= 1'b1;
                pc_load_addr_reg <= `RIV_VEC_START;
            end else if (take_irq) begin
                mask_reg         <= 1'b1;
                active_vec_reg   <= lowest_vec;
                pc_load_reg      <= 1'b1;
                pc_load_addr_reg <= {11'h000, lowest_vec};
            end else if (irq_unmask_instr && state_reg == RIV_ST_RUN) begin
                mask_reg <= 1'b0;
            end
        end
    end

    // Shadow capture of fetch, decode and execute stages
    always_ff @(posedge clk) begin
        if (srst) begin
            status_return_reg  <= `RIV_WORD_RST;
            pc_return_reg      <= `RIV_WORD_RST;
            instr_return_reg   <= 22'h00_0000;
            scratch_result_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (save_ctx) begin
                pc_return_reg      <= fetch_addr;
                instr_return_reg   <= decode_instr;
                status_return_reg  <= exec_status;
                scratch_result_reg <= temp_result;
            end else if (reg_wr_en) begin
                // Scratch halves are read-only; writes there drop
                case (reg_addr)
                    `RIV_ADDR_STAT_RET: status_return_reg <= reg_wr_data;
                    `RIV_ADDR_PC_RET:   pc_return_reg <= reg_wr_data;
                    `RIV_ADDR_INSTR_LO: instr_return_reg[15:0] <= reg_wr_data;
                    `RIV_ADDR_INSTR_HI:
                        instr_return_reg[21:16] <= reg_wr_data[5:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Return hands the saved context back to the pipeline
    always_ff @(posedge clk) begin
        if (srst) begin
            restore_valid_reg <= 1'b0;
        end else if (ce) begin
            restore_valid_reg <= return_instr &&
                                 state_reg == RIV_ST_RUN;
        end
    end

    // Core-only reads; no host port reaches this space
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_reg  <= `RIV_WORD_RST;
            rd_valid_reg <= 1'b0;
            ack_reg      <= 32'h0000_0000;
        end else if (ce) begin
            rd_valid_reg <= reg_rd_en;
            ack_reg      <= ack_read ? vec_onehot(active_vec_reg)
                                     : 32'h0000_0000;
            case (reg_addr)
                `RIV_ADDR_VEC_ACK:  rd_data_reg <= {11'h000, active_vec_reg};
                `RIV_ADDR_STAT_RET:
                    rd_data_reg <= status_return_reg;
                `RIV_ADDR_PC_RET:   rd_data_reg <= pc_return_reg;
                `RIV_ADDR_INSTR_LO: rd_data_reg <= instr_return_reg[15:0];
                `RIV_ADDR_INSTR_HI:
                    rd_data_reg <= {10'h000, instr_return_reg[21:16]};
                `RIV_ADDR_SCR_HI:   rd_data_reg <= scratch_result_reg[31:16];
                `RIV_ADDR_SCR_LO:   rd_data_reg <= scratch_result_reg[15:0];
                default:            rd_data_reg <= `RIV_WORD_RST;
            endcase
        end
    end

    // Segment has no read path
    always_ff @(posedge clk) begin
        if (srst) begin
            data_segment_reg <= `RIV_SEG_RST;
        end else if (ce && set_segment_instr) begin
            data_segment_reg <= seg_imm;
        end
    end

    // Address is built from port A of the register file
    assign daddr_next = {data_segment_reg, rs_a_data};

    always_ff @(posedge clk) begin
        if (srst) begin
            mem_valid_reg  <= 1'b0;
            mem_addr_reg   <= 21'h0_0000;
            mem_region_reg <= RIV_REG_SPACE;
        end else if (ce) begin
            mem_valid_reg <= mem_req;
            if (mem_req) begin
                mem_addr_reg <= daddr_next;
                // External memory never aliases the low 1K
                if (daddr_next >= `RIV_EXT_BASE) begin
                    mem_region_reg <= RIV_EXT_MEM;
                end else if (daddr_next >= `RIV_DM_BASE) begin
                    mem_region_reg <= RIV_INT_DM;
                end else begin
                    mem_region_reg <= RIV_REG_SPACE;
                end
            end
        end
    end

    riv_gpr_file u_gpr (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .rs_a_sel  (rs_a_sel),
        .rs_b_sel  (rs_b_sel),
        .rs_a_data (rs_a_data),
        .rs_b_data (rs_b_data),
        .wb_en     (wb_en),
        .wb_sel    (wb_sel),
        .wb_data   (wb_data)
    );

    assign engine_ack     = ack_reg[15:1];
    assign dma_tc_ack     = ack_reg[31:16];
    assign irq_masked     = mask_reg;
    assign core_running   = state_reg == RIV_ST_RUN;
    assign pc_load        = pc_load_reg;
    assign pc_load_addr   = pc_load_addr_reg;
    assign restore_valid  = restore_valid_reg;
    assign restore_pc     = pc_return_reg;
    assign restore_instr  = instr_return_reg;
    assign restore_status = status_return_reg;
    assign reg_rd_data    = rd_data_reg;
    assign reg_rd_valid   = rd_valid_reg;
    assign mem_valid      = mem_valid_reg;
    assign mem_addr       = mem_addr_reg;
    assign mem_region     = mem_region_reg;

    start_vec_a: assert property (@(posedge clk) disable iff (srst)
        (ce && start_core) |=> (pc_load && pc_load_addr == 16'h0000))
        else $error("start did not load vector 0");

    take_mask_a: assert property (@(posedge clk) disable iff (srst)
        (ce && take_irq) |=> (irq_masked && pc_load)
        ##1 (irq_masked || $past(irq_unmask_instr)))
        else $error("interrupt taken without masking");

    take_lowest_a: assert property (@(posedge clk) disable iff (srst)
        (ce && take_irq) |=>
        (pc_load_addr[4:0] == $past(lowest_set(pending_reg))
         && pc_load_addr[15:5] == 11'h000))
        else $error("wrong vector taken");

    ack_pulse_a: assert property (@(posedge clk) disable iff (srst)
        (ce && ack_read) |=>
        ({dma_tc_ack, engine_ack, 1'b0} ==
         (vec_onehot($past(active_vec_reg)) & 32'hFFFF_FFFE)))
        else $error("acknowledge missing or misrouted");

    unmask_ei_a: assert property (@(posedge clk) disable iff (srst)
        (ce && irq_unmask_instr && core_running && !take_irq && !start_core)
        |=> !irq_masked)
        else $error("unmask did not clear mask");

    call_save_a: assert property (@(posedge clk) disable iff (srst)
        (ce && call_exec && core_running) |=>
        (restore_pc == $past(fetch_addr) &&
         restore_instr == $past(decode_instr)))
        else $error("call did not save context");

    ret_restore_a: assert property (@(posedge clk) disable iff (srst)
        (ce && save_ctx) ##1 (ce && return_instr && !reg_wr_en && !call_exec)
        |=> (restore_valid && restore_pc == $past(fetch_addr, 2)))
        else $error("return lost saved address");

    seg_addr_a: assert property (@(posedge clk) disable iff (srst)
        (ce && mem_req) |=> (mem_valid &&
        mem_addr == {$past(data_segment_reg), $past(rs_a_data)}))
        else $error("data address not segment and register");

    region_map_a: assert property (@(posedge clk) disable iff (srst)
        mem_valid |-> ((mem_addr < 21'h0_0400) == (mem_region != RIV_EXT_MEM)))
        else $error("external region below 400h");
endmodule

// file: riv_irq_source.sv
`timescale 1ns/1ps

module riv_irq_source (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [30:0] raise,
    input  wire logic [14:0] engine_ack,
    input  wire logic [15:0] dma_tc_ack,
    output logic      [14:0] engine_irq,
    output logic      [15:0] dma_tc_irq
);
    // Sources hold the request level until acknowledged
    always_ff @(posedge clk) begin
        if (srst) begin
            engine_irq <= 15'h0000;
            dma_tc_irq <= 16'h0000;
        end else begin
            engine_irq <= (engine_irq | raise[14:0]) & ~engine_ack;
            dma_tc_irq <= (dma_tc_irq | raise[30:15]) & ~dma_tc_ack;
        end
    end
endmodule

// file: riv_exception_unit_test.sv
`timescale 1ns/1ps

module riv_exception_unit_test;
    import riv_pkg::*;
    typedef struct packed {
        logic [4:0]  seg;
        logic [4:0]  sel;
        logic [15:0] val;
        logic [20:0] addr;
        riv_region_t rgn;
    } riv_row_t;
    riv_row_t rows [7] = '{
        '{5'h00, 5'h01, 16'h01FF, 21'h00_01FF, RIV_REG_SPACE},
        '{5'h00, 5'h02, 16'h0200, 21'h00_0200, RIV_INT_DM},
        '{5'h00, 5'h03, 16'h03FF, 21'h00_03FF, RIV_INT_DM},
        '{5'h00, 5'h04, 16'h0400, 21'h00_0400, RIV_EXT_MEM},
        '{5'h1F, 5'h05, 16'hFFFF, 21'h1F_FFFF, RIV_EXT_MEM},
        '{5'h10, 5'h00, 16'h1234, 21'h10_0000, RIV_EXT_MEM},
        '{5'h01, 5'h06, 16'h0000, 21'h01_0000, RIV_EXT_MEM}};
    logic        clk, srst, ce, core_enable, irq_masked, core_running;
    logic        call_exec, irq_unmask_instr, return_instr;
    logic        set_segment_instr, pc_load, restore_valid;
    logic        reg_rd_en, reg_wr_en, reg_rd_valid, wb_en, mem_req;
    logic        mem_valid;
    logic [14:0] engine_irq, engine_ack;
    logic [15:0] dma_tc_irq, dma_tc_ack, fetch_addr, exec_status;
    logic [15:0] pc_load_addr, restore_pc, restore_status, reg_wr_data;
    logic [15:0] reg_rd_data, rs_a_data, rs_b_data, wb_data;
    logic [21:0] decode_instr, restore_instr;
    logic [31:0] temp_result;
    logic [30:0] raise;
    logic [4:0]  seg_imm, rs_a_sel, rs_b_sel, wb_sel;
    logic [8:0]  reg_addr;
    logic [20:0] mem_addr;
    riv_region_t mem_region;
    int          failures = 0;
    int          n_checks = 0;

    riv_exception_unit u_riv_exception_unit (.clk(clk), .srst(srst),
        .ce(ce), .core_enable(core_enable), .engine_irq(engine_irq),
        .dma_tc_irq(dma_tc_irq), .engine_ack(engine_ack),
        .dma_tc_ack(dma_tc_ack), .irq_masked(irq_masked),
        .core_running(core_running), .fetch_addr(fetch_addr),
        .decode_instr(decode_instr), .exec_status(exec_status),
        .temp_result(temp_result), .call_exec(call_exec),
        .irq_unmask_instr(irq_unmask_instr), .return_instr(return_instr),
        .set_segment_instr(set_segment_instr), .seg_imm(seg_imm),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .restore_valid(restore_valid), .restore_pc(restore_pc),
        .restore_instr(restore_instr), .restore_status(restore_status),
        .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .rs_a_sel(rs_a_sel),
        .rs_b_sel(rs_b_sel), .rs_a_data(rs_a_data), .rs_b_data(rs_b_data),
        .wb_en(wb_en), .wb_sel(wb_sel), .wb_data(wb_data),
        .mem_req(mem_req), .mem_valid(mem_valid), .mem_addr(mem_addr),
        .mem_region(mem_region));

    riv_irq_source u_riv_irq_source (.clk(clk), .srst(srst), .raise(raise),
        .engine_ack(engine_ack), .dma_tc_ack(dma_tc_ack),
        .engine_irq(engine_irq), .dma_tc_irq(dma_tc_irq));

    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        chk({31'h0, reg_rd_valid}, 32'h0000_0001);
        chk({16'h0, reg_rd_data}, {16'h0, exp});
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask

    // Bounded wait so a lost interrupt cannot hang the run
    task automatic wait_pc(input logic [15:0] exp);
        int i;
        i = 0;
        while (pc_load !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        chk({31'h0, pc_load}, 32'h0000_0001);
        chk({16'h0, pc_load_addr}, {16'h0, exp});
    endtask

    task automatic pulse_unmask();
        irq_unmask_instr = 1'b1;
        @(negedge clk);
        irq_unmask_instr = 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #50000;
        failures++;
        final_report();
    end

    initial begin
        {clk, ce, core_enable, call_exec, irq_unmask_instr} = 5'h08;
        {return_instr, set_segment_instr, reg_rd_en, reg_wr_en} = 4'h0;
        {wb_en, mem_req, seg_imm, rs_a_sel, rs_b_sel, wb_sel} = 22'h0;
        {reg_addr, reg_wr_data, wb_data, raise} = 72'h0;
        fetch_addr = 16'h1234;
        decode_instr = 22'h2A_5A5A;
        exec_status = 16'h00C3;
        temp_result = 32'hDEAD_BEEF;
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk({30'h0, irq_masked, core_running}, 32'h0000_0002);
        core_enable = 1'b1;
        wait_pc(16'h0000);
        chk({30'h0, irq_masked, core_running}, 32'h0000_0001);
        $display("start test done");
        for (int i = 0; i < 7; i++) begin
            set_segment_instr = 1'b1;
            seg_imm = rows[i].seg;
            wb_en = 1'b1;
            wb_sel = rows[i].sel;
            wb_data = rows[i].val;
            @(negedge clk);
            set_segment_instr = 1'b0;
            wb_en = 1'b0;
            mem_req = 1'b1;
            rs_a_sel = rows[i].sel;
            rs_b_sel = rows[i].sel;
            @(negedge clk);
            mem_req = 1'b0;
            chk({31'h0, mem_valid}, 32'h0000_0001);
            chk({11'h0, mem_addr}, {11'h0, rows[i].addr});
            chk({16'h0, rs_b_data}, 32'(rows[i].addr[15:0]));
            chk({29'h0, mem_region}, {29'h0, rows[i].rgn});
        end
        $display("address table done");
        raise = 31'h0002_0040;
        @(negedge clk);
        raise = 31'h0;
        wait_pc(16'h0007);
        chk({31'h0, irq_masked}, 32'h0000_0001);
        rd_chk(9'h008, 16'h00C3);
        rd_chk(9'h009, 16'h1234);
        rd_chk(9'h00A, 16'h5A5A);
        rd_chk(9'h00B, 16'h002A);
        wr(9'h00C, 16'h1111);
        rd_chk(9'h00C, 16'hDEAD);
        rd_chk(9'h00D, 16'hBEEF);
        rd_chk(9'h1F0, 16'h0000);
        wr(9'h009, 16'h5555);
        return_instr = 1'b1;
        @(negedge clk);
        return_instr = 1'b0;
        chk({15'h0, restore_valid, restore_pc}, 32'h0001_5555);
        chk({16'h0, restore_status}, 32'h0000_00C3);
        chk({10'h0, restore_instr}, 32'h002A_5A5A);
        rd_chk(9'h007, 16'h0007);
        chk({17'h0, engine_ack}, 32'h0000_0040);
        pulse_unmask();
        wait_pc(16'h0012);
        rd_chk(9'h007, 16'h0012);
        chk({16'h0, dma_tc_ack}, 32'h0000_0004);
        pulse_unmask();
        $display("priority test done");
        fetch_addr = 16'h0ABC;
        call_exec = 1'b1;
        @(negedge clk);
        call_exec = 1'b0;
        rd_chk(9'h009, 16'h0ABC);
        $display("call test done");
        for (int v = 1; v < 32; v++) begin
            raise = 31'h1 << (v - 1);
            @(negedge clk);
            raise = 31'h0;
            wait_pc(v[15:0]);
            rd_chk(9'h007, v[15:0]);
            chk({1'b0, dma_tc_ack, engine_ack}, 32'h1 << (v - 1));
            pulse_unmask();
        end
        $display("vector test done");
        core_enable = 1'b0;
        @(negedge clk);
        chk({31'h0, core_running}, 32'h0000_0000);
        core_enable = 1'b1;
        wait_pc(16'h0000);
        $display("restart test done");
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk({29'h0, pc_load, irq_masked, core_running}, 32'h2);
        wait_pc(16'h0000);
        $display("reset test done");
        final_report();
    end
endmodule
